// ==== core/dli_indicator.v ====
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "dli_defines.vh"

// Operation
// - Main lamp shows orange after reset until startup time ends, then state colours.
// - Each lamp supports off, on, slow flash and fast flash from the clock.
// - No fault present: main lamp steady green.
// - Commissioning or factory reset: main lamp flashes green slowly.
// - Firmware update running: main lamp red on, bus lamp yellow variable rate.
// - Awaiting power cycle after update: main and bus lamps flash red slowly.
// - Fault present: main lamp flashes red fast.
// - Wrong card or failed update: main and bus lamps flash red fast.
// - Fieldbus link in order: link lamp steady green.
// - Device naming active: link lamp flashes green slowly.
// - No fieldbus communication: link lamp off.
// - RS485 exchanging data: bus lamp off.
// - RS485 bus active without process data: bus lamp red slow.
// - RS485 no bus connection: bus lamp red fast.
// - Token bus cyclic exchange running: bus lamp steady green.
// - Token bus not in use: bus lamp off.
// - Token bus configuration or bus fault: bus lamp red slow.
// - Token bus no exchange, baud search or no connection: bus lamp red fast.
// - Safety enabled but none active: safety lamp steady yellow.
// - Safety active without safety fault: safety lamp yellow slow.
// - Safety fault: request stop and flash safety lamp yellow fast.
module dli_indicator #(
  parameter integer SLOW_HALF = `DLI_SLOW_MS * `DLI_MS_CYCLES / 2,
  parameter integer FAST_HALF = `DLI_FAST_MS * `DLI_MS_CYCLES / 2,
  parameter integer VAR_HALF = `DLI_VAR_MS * `DLI_MS_CYCLES / 2,
  parameter integer ORANGE_CYCLES = `DLI_ORANGE_MS * `DLI_MS_CYCLES,
  parameter integer CW = 28
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Device state, asynchronous
  input wire fault_present,
  input wire commissioning,
  input wire factory_reset,
  input wire fw_update_active,
  input wire fw_wait_power_cycle,
  input wire fw_update_failed,
  input wire card_error,
  input wire link_ok,
  input wire naming_active,
  input wire bus_data_exchange,
  input wire bus_active_no_data,
  input wire bus_no_connection,
  input wire bus_config_fault,
  input wire bus_baud_search,
  input wire safety_enabled,
  input wire safety_active,
  input wire safety_fault,
  // Lamps: bit 0 green, bit 1 red, both for orange and yellow
  output reg [1:0] main_lamp,
  output reg [1:0] bus_fault_lamp,
  output reg [1:0] link_lamp,
  output reg [1:0] safety_lamp,
  output reg safety_stop_req
);

  localparam integer NIN = 17;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  wire [NIN-1:0] raw_in = {
    safety_fault,
    safety_active,
    safety_enabled,
    bus_baud_search,
    bus_config_fault,
    bus_no_connection,
    bus_active_no_data,
    bus_data_exchange,
    naming_active,
    link_ok,
    card_error,
    fw_update_failed,
    fw_wait_power_cycle,
    fw_update_active,
    factory_reset,
    commissioning,
    fault_present
  };
  reg [NIN-1:0] meta_q;
  reg [NIN-1:0] sync_q;
  always @(posedge clock) begin
    if (rst) begin
      meta_q <= {NIN{1'b0}};
      sync_q <= {NIN{1'b0}};
    end else begin
      meta_q <= raw_in;
      sync_q <= meta_q;
    end
  end
  wire s_fault = sync_q[0];
  wire s_comm = sync_q[1] | sync_q[2];
  wire s_upd = sync_q[3];
  wire s_wait = sync_q[4];
  wire s_card = sync_q[5] | sync_q[6];
  wire s_link = sync_q[7];
  wire s_name = sync_q[8];
  wire s_xchg = sync_q[9];
  wire s_nodata = sync_q[10];
  wire s_nocon = sync_q[11];
  wire s_cfg = sync_q[12];
  wire s_baud = sync_q[13];
  wire s_sen = sync_q[14];
  wire s_sact = sync_q[15];
  wire s_sflt = sync_q[16];

  ////////////////////////////////////////////////////////////////////////
  // Control register
  reg [`DLI_CTRL_WIDTH-1:0] bus_sel_q;
  always @(posedge clock) begin
    if (rst) begin
      bus_sel_q <= `DLI_CTRL_RESET;
    end else if (reg_wr && reg_addr == `DLI_ADDR_CTRL) begin
      bus_sel_q <= reg_wdata[`DLI_CTRL_BUS_MSB:`DLI_CTRL_BUS_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flash generators, one per rate
  localparam [3*CW-1:0] HALVES = {VAR_HALF[CW-1:0], FAST_HALF[CW-1:0], SLOW_HALF[CW-1:0]};
  // One driver per phase bit, gathered onto a wire
  wire [2:0] phase_q;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_flash
      reg [CW-1:0] cnt_q;
      reg ph_q;
      always @(posedge clock) begin
        if (rst) begin
          cnt_q <= {CW{1'b0}};
          ph_q <= 1'b0;
        end else if (cnt_q >= HALVES[g*CW +: CW] - 1'b1) begin
          cnt_q <= {CW{1'b0}};
          ph_q <= ~ph_q;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
      assign phase_q[g] = ph_q;
    end
  endgenerate

  // Variable rate: toggle period alternates with the fast phase
  wire var_phase = phase_q[1] ? phase_q[2] : phase_q[0];

  ////////////////////////////////////////////////////////////////////////
  // Startup orange interval
  localparam [1:0] ST_BOOT = 2'b00;
  localparam [1:0] ST_RUN = 2'b01;
  reg [1:0] boot_st_q;
  reg [1:0] boot_st_d;
  reg [CW-1:0] boot_cnt_q;
  reg [CW-1:0] boot_cnt_d;
  wire booted = (boot_st_q == ST_RUN);
  always @* begin
    boot_st_d = boot_st_q;
    boot_cnt_d = boot_cnt_q;
    case (boot_st_q)
      ST_BOOT: begin
        if (boot_cnt_q >= ORANGE_CYCLES[CW-1:0] - 1'b1) begin
          boot_st_d = ST_RUN;
        end else begin
          boot_cnt_d = boot_cnt_q + 1'b1;
        end
      end
      ST_RUN: begin
        // Counter frozen, orange only returns with reset
        boot_st_d = ST_RUN;
      end
      default: begin
        boot_st_d = ST_BOOT;
      end
    endcase
  end
  always @(posedge clock) begin
    if (rst) begin
      boot_st_q <= ST_BOOT;
      boot_cnt_q <= {CW{1'b0}};
    end else begin
      boot_st_q <= boot_st_d;
      boot_cnt_q <= boot_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pattern selection
  reg [1:0] main_col;
  reg [1:0] bus_col;
  reg [1:0] link_col;
  reg [2:0] main_pat;
  reg [2:0] bus_pat;
  reg [2:0] link_pat;
  reg [2:0] safe_pat;
  always @* begin
    main_col = `DLI_COL_GREEN;
    main_pat = `DLI_PAT_ON;
    bus_col = `DLI_COL_OFF;
    bus_pat = `DLI_PAT_OFF;
    // Bus lamp from selected fieldbus first; device-wide states override below
    if (bus_sel_q == `DLI_BUS_RS485) begin
      if (s_nocon) begin
        bus_col = `DLI_COL_RED;
        bus_pat = `DLI_PAT_FAST;
      end else if (s_nodata) begin
        bus_col = `DLI_COL_RED;
        bus_pat = `DLI_PAT_SLOW;
      end else begin
        bus_pat = `DLI_PAT_OFF;
      end
    end else if (bus_sel_q == `DLI_BUS_TOKEN) begin
      if (s_nocon || s_baud || s_nodata) begin
        bus_col = `DLI_COL_RED;
        bus_pat = `DLI_PAT_FAST;
      end else if (s_cfg) begin
        bus_col = `DLI_COL_RED;
        bus_pat = `DLI_PAT_SLOW;
      end else if (s_xchg) begin
        bus_col = `DLI_COL_GREEN;
        bus_pat = `DLI_PAT_ON;
      end
    end else begin
      bus_pat = `DLI_PAT_OFF;
    end
    // Main lamp, highest priority last
    if (s_comm) begin
      main_pat = `DLI_PAT_SLOW;
    end
    if (s_fault) begin
      main_col = `DLI_COL_RED;
      main_pat = `DLI_PAT_FAST;
    end
    if (s_wait) begin
      main_col = `DLI_COL_RED;
      main_pat = `DLI_PAT_SLOW;
      bus_col = `DLI_COL_RED;
      bus_pat = `DLI_PAT_SLOW;
    end
    if (s_card) begin
      main_col = `DLI_COL_RED;
      main_pat = `DLI_PAT_FAST;
      bus_col = `DLI_COL_RED;
      bus_pat = `DLI_PAT_FAST;
    end
    if (s_upd) begin
      main_col = `DLI_COL_RED;
      main_pat = `DLI_PAT_ON;
      bus_col = `DLI_COL_YELLOW;
      bus_pat = `DLI_PAT_VAR;
    end
    // Link lamp
    link_col = `DLI_COL_GREEN;
    if (s_name) begin
      link_pat = `DLI_PAT_SLOW;
    end else if (s_link) begin
      link_pat = `DLI_PAT_ON;
    end else begin
      link_pat = `DLI_PAT_OFF;
    end
    // Safety lamp
    if (s_sflt) begin
      safe_pat = `DLI_PAT_FAST;
    end else if (s_sact) begin
      safe_pat = `DLI_PAT_SLOW;
    end else if (s_sen) begin
      safe_pat = `DLI_PAT_ON;
    end else begin
      safe_pat = `DLI_PAT_OFF;
    end
  end

  function [1:0] lamp_drive;
    input [1:0] col;
    input [2:0] pat;
    input [2:0] ph;
    input vph;
    begin
      case (pat)
        `DLI_PAT_ON: lamp_drive = col;
        `DLI_PAT_SLOW: lamp_drive = ph[0] ? col : `DLI_COL_OFF;
        `DLI_PAT_FAST: lamp_drive = ph[1] ? col : `DLI_COL_OFF;
        `DLI_PAT_VAR: lamp_drive = vph ? col : `DLI_COL_OFF;
        default: lamp_drive = `DLI_COL_OFF;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registered lamp outputs
  always @(posedge clock) begin
    if (rst) begin
      main_lamp <= `DLI_COL_YELLOW;
      bus_fault_lamp <= `DLI_COL_OFF;
      link_lamp <= `DLI_COL_OFF;
      safety_lamp <= `DLI_COL_OFF;
      safety_stop_req <= 1'b0;
    end else begin
      // Other lamps stay dark until startup ends so nothing misleads early
      if (!booted) begin
        main_lamp <= `DLI_COL_YELLOW;
        bus_fault_lamp <= `DLI_COL_OFF;
        link_lamp <= `DLI_COL_OFF;
        safety_lamp <= `DLI_COL_OFF;
      end else begin
        main_lamp <= lamp_drive(main_col, main_pat, phase_q, var_phase);
        bus_fault_lamp <= lamp_drive(bus_col, bus_pat, phase_q, var_phase);
        link_lamp <= lamp_drive(link_col, link_pat, phase_q, var_phase);
        safety_lamp <= lamp_drive(`DLI_COL_YELLOW, safe_pat, phase_q, var_phase);
      end
      // Stop request is not held back by startup
      safety_stop_req <= s_sflt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read
  always @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `DLI_ADDR_CTRL: reg_rdata <= {6'h00, bus_sel_q};
        `DLI_ADDR_STAT: reg_rdata <= {
          booted,
          safety_stop_req,
          s_upd,
          s_wait,
          s_card,
          s_fault,
          s_comm,
          s_link
        };
        `DLI_ADDR_LAMP: reg_rdata <= {main_lamp, bus_fault_lamp, link_lamp, safety_lamp};
        `DLI_ADDR_ID: reg_rdata <= `DLI_ID_VALUE;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // dli_indicator

// ==== core/dli_defines.vh ====
`ifndef DLI_DEFINES_VH
`define DLI_DEFINES_VH

// Register offsets
`define DLI_ADDR_CTRL 4'h0
`define DLI_ADDR_STAT 4'h1
`define DLI_ADDR_LAMP 4'h2
`define DLI_ADDR_ID 4'h3

// Control register fields
`define DLI_CTRL_BUS_LSB 0
`define DLI_CTRL_BUS_MSB 1
`define DLI_CTRL_WIDTH 2
`define DLI_CTRL_RESET 2'h0

// Bus selection codes
`define DLI_BUS_NONE 2'h0
`define DLI_BUS_RS485 2'h1
`define DLI_BUS_TOKEN 2'h2

// Colour codes
`define DLI_COL_OFF 2'h0
`define DLI_COL_GREEN 2'h1
`define DLI_COL_RED 2'h2
`define DLI_COL_YELLOW 2'h3

// Pattern codes
`define DLI_PAT_OFF 3'h0
`define DLI_PAT_ON 3'h1
`define DLI_PAT_SLOW 3'h2
`define DLI_PAT_FAST 3'h3
`define DLI_PAT_VAR 3'h4

// Flash timing
`define DLI_CLK_MHZ 250
`define DLI_SLOW_MS 500
`define DLI_FAST_MS 125
`define DLI_VAR_MS 50
`define DLI_ORANGE_MS 1000
`define DLI_MS_CYCLES (`DLI_CLK_MHZ * 1000)

// Arbitrary identification value
`define DLI_ID_VALUE 8'h5A

`endif

// ==== bench/dli_indicator_chk.sv ====
`timescale 1ns/1ps
module dli_indicator_chk #(
  parameter integer ORANGE_CYCLES = 20
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Register port
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // State inputs
  input wire link_ok,
  input wire naming_active,
  input wire fw_update_active,
  input wire safety_enabled,
  input wire safety_active,
  input wire safety_fault,
  // Lamps
  input wire [1:0] main_lamp,
  input wire [1:0] link_lamp,
  input wire [1:0] safety_lamp,
  input wire safety_stop_req
);
  reg [31:0] cnt_q;
  wire booted;
  // Margin past the orange time, state lamps judged only after it
  assign booted = cnt_q > ORANGE_CYCLES + 2;
  always @(posedge clock) begin
    if (rst)
      cnt_q <= 32'h0;
    else if (!booted)
      cnt_q <= cnt_q + 32'h1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  AST_BOOT_ORANGE: assert property (cnt_q < ORANGE_CYCLES - 1 |-> main_lamp == 2'h3)
    else $error("main lamp not orange at startup");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read");
  AST_LINK_ON: assert property (booted && (link_ok && !naming_active) [*4] |-> link_lamp == 2'h1)
    else $error("link lamp not steady green");
  AST_LINK_OFF: assert property (booted && (!link_ok && !naming_active) [*4] |-> link_lamp == 2'h0)
    else $error("link lamp not off");
  AST_UPD_RED: assert property (booted && fw_update_active [*4] |-> main_lamp == 2'h2)
    else $error("main lamp not steady red in update");
  AST_SAFE_ON: assert property (booted && (safety_enabled && !safety_active && !safety_fault) [*4]
    |-> safety_lamp == 2'h3)
    else $error("safety lamp not steady yellow");
  AST_STOP: assert property (safety_fault [*4] |-> safety_stop_req)
    else $error("stop request missing");
  AST_STOP_LOW: assert property (!safety_fault [*4] |-> !safety_stop_req)
    else $error("stop request without fault");
  AST_SAFE_FLASH: assert property (booted && safety_fault [*4] |-> ##[1:3] safety_lamp != $past(safety_lamp))
    else $error("safety lamp not flashing fast");
endmodule // dli_indicator_chk

// ==== bench/dli_lamp_view.sv ====
`timescale 1ns/1ps
module dli_lamp_view (
  // Clock and clear
  input wire clock,
  input wire clr,
  // Lamp as the operator sees it
  input wire [1:0] lamp,
  // Lit colour and last segment length, F when steady
  output reg [1:0] col_q,
  output wire [3:0] len
);
  reg [1:0] prev_q;
  reg [3:0] run_q;
  reg [3:0] len_q;
  // First segment after clear is partial, so wait for later ones
  assign len = (run_q == 4'hF) ? 4'hF : len_q;
  always @(posedge clock) begin
    prev_q <= lamp;
    if (clr) begin
      col_q <= 2'h0;
      run_q <= 4'h0;
      len_q <= 4'h0;
    end else begin
      if (lamp != 2'h0)
        col_q <= lamp;
      if (lamp != prev_q) begin
        len_q <= run_q;
        run_q <= 4'h1;
      end else if (run_q != 4'hF)
        run_q <= run_q + 4'h1;
    end
  end
endmodule // dli_lamp_view

// ==== bench/dli_indicator_tb.sv ====
`timescale 1ns/1ps
`include "dli_defines.vh"
module dli_indicator_tb;
  reg clock;
  reg rst;
  reg [3:0] reg_addr;
  reg [7:0] reg_wdata;
  reg reg_wr;
  reg reg_rd;
  reg clr;
  reg [16:0] st;
  reg [7:0] rd_q;
  reg [36:0] rows [0:16];
  wire [7:0] reg_rdata;
  wire [1:0] main_lamp, bus_fault_lamp, link_lamp, safety_lamp, mcol, bcol, scol;
  wire [3:0] mlen, blen, slen;
  wire safety_stop_req;
  integer num_errors, num_checks, i;
  dli_indicator #(.SLOW_HALF(8), .FAST_HALF(2), .VAR_HALF(1), .ORANGE_CYCLES(20), .CW(8)) uut (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fault_present(st[16]), .commissioning(st[15]), .factory_reset(st[14]),
    .fw_update_active(st[13]), .fw_wait_power_cycle(st[12]), .fw_update_failed(st[11]), .card_error(st[10]),
    .link_ok(st[9]), .naming_active(st[8]), .bus_data_exchange(st[7]), .bus_active_no_data(st[6]),
    .bus_no_connection(st[5]), .bus_config_fault(st[4]), .bus_baud_search(st[3]), .safety_enabled(st[2]),
    .safety_active(st[1]), .safety_fault(st[0]), .main_lamp(main_lamp), .bus_fault_lamp(bus_fault_lamp),
    .link_lamp(link_lamp), .safety_lamp(safety_lamp), .safety_stop_req(safety_stop_req));
  dli_lamp_view vm (.clock(clock), .clr(clr), .lamp(main_lamp), .col_q(mcol), .len(mlen));
  dli_lamp_view vb (.clock(clock), .clr(clr), .lamp(bus_fault_lamp), .col_q(bcol), .len(blen));
  dli_lamp_view vs (.clock(clock), .clr(clr), .lamp(safety_lamp), .col_q(scol), .len(slen));
  ////////////////////////////////////////
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  // Idle cycle after each strobe keeps transfers apart
  task wr(input logic [3:0] a, input logic [7:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      @(posedge clock);
    end
  endtask
  task rd(input logic [3:0] a);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      // Data stand one cycle only, taken mid-cycle to avoid the edge race
      @(negedge clock);
      rd_q = reg_rdata;
      @(posedge clock);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    repeat (4000) @(posedge clock);
    num_errors = num_errors + 1;
    wrap_up;
  end
  initial begin
    num_errors = 0;
    num_checks = 0;
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    clr = 1'b0;
    st = 17'h0;
    // Select, state, main col/len, bus col/len, safety col/len; bus len 0 not judged
    rows[0] = {2'h0, 17'h00204, 2'h1, 4'hF, 2'h0, 4'hF, 2'h3, 4'hF};
    rows[1] = {2'h0, 17'h08000, 2'h1, 4'h8, 2'h0, 4'hF, 2'h0, 4'hF};
    rows[2] = {2'h0, 17'h04000, 2'h1, 4'h8, 2'h0, 4'hF, 2'h0, 4'hF};
    rows[3] = {2'h0, 17'h12000, 2'h2, 4'hF, 2'h3, 4'h0, 2'h0, 4'hF};
    rows[4] = {2'h1, 17'h01000, 2'h2, 4'h8, 2'h2, 4'h8, 2'h0, 4'hF};
    rows[5] = {2'h0, 17'h10001, 2'h2, 4'h2, 2'h0, 4'hF, 2'h3, 4'h2};
    rows[6] = {2'h2, 17'h10400, 2'h2, 4'h2, 2'h2, 4'h2, 2'h0, 4'hF};
    rows[7] = {2'h1, 17'h00800, 2'h2, 4'h2, 2'h2, 4'h2, 2'h0, 4'hF};
    rows[8] = {2'h1, 17'h00180, 2'h1, 4'hF, 2'h0, 4'hF, 2'h0, 4'hF};
    rows[9] = {2'h1, 17'h00040, 2'h1, 4'hF, 2'h2, 4'h8, 2'h0, 4'hF};
    rows[10] = {2'h1, 17'h00060, 2'h1, 4'hF, 2'h2, 4'h2, 2'h0, 4'hF};
    rows[11] = {2'h2, 17'h00082, 2'h1, 4'hF, 2'h1, 4'hF, 2'h3, 4'h8};
    rows[12] = {2'h2, 17'h00010, 2'h1, 4'hF, 2'h2, 4'h8, 2'h0, 4'hF};
    rows[13] = {2'h2, 17'h00008, 2'h1, 4'hF, 2'h2, 4'h2, 2'h0, 4'hF};
    rows[14] = {2'h2, 17'h00020, 2'h1, 4'hF, 2'h2, 4'h2, 2'h0, 4'hF};
    rows[15] = {2'h2, 17'h00040, 2'h1, 4'hF, 2'h2, 4'h2, 2'h0, 4'hF};
    rows[16] = {2'h0, 17'h00090, 2'h1, 4'hF, 2'h0, 4'hF, 2'h0, 4'hF};
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("main_boot", 8'h03, 8'(main_lamp));
    rd(`DLI_ADDR_ID);
    chk("id", `DLI_ID_VALUE, rd_q);
    rd(4'hF);
    chk("unmapped", 8'h00, rd_q);
    repeat (30) @(posedge clock);
    for (i = 0; i < 17; i = i + 1) begin
      wr(`DLI_ADDR_CTRL, 8'(rows[i][36:35]));
      rd(`DLI_ADDR_CTRL);
      chk("ctrl", 8'(rows[i][36:35]), rd_q);
      st <= rows[i][34:18];
      repeat (6) @(posedge clock);
      clr <= 1'b1;
      @(posedge clock);
      clr <= 1'b0;
      repeat (40) @(posedge clock);
      chk("main_col", 8'(rows[i][17:16]), 8'(mcol));
      chk("bus_col", 8'(rows[i][11:10]), 8'(bcol));
      chk("safe_col", 8'(rows[i][5:4]), 8'(scol));
      chk("main_len", 8'(rows[i][15:12]), 8'(mlen));
      if (rows[i][9:6] != 4'h0)
        chk("bus_len", 8'(rows[i][9:6]), 8'(blen));
      chk("safe_len", 8'(rows[i][3:0]), 8'(slen));
    end
    rd(`DLI_ADDR_STAT);
    chk("stat", 8'h80, rd_q);
    rd(`DLI_ADDR_LAMP);
    chk("lamp", 8'h40, rd_q);
    st <= 17'h10000;
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (5) @(posedge clock);
    chk("main_rst", 8'h03, 8'(main_lamp));
    rd(`DLI_ADDR_CTRL);
    chk("ctrl_rst", 8'h00, rd_q);
    wrap_up;
  end
endmodule // dli_indicator_tb
bind dli_indicator dli_indicator_chk #(.ORANGE_CYCLES(ORANGE_CYCLES)) chk (.clock, .rst, .reg_rd, .reg_rdata,
  .link_ok, .naming_active, .fw_update_active, .safety_enabled, .safety_active, .safety_fault, .main_lamp,
  .link_lamp, .safety_lamp, .safety_stop_req);
